// [core/sbet_pkg.sv]
package sbet_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_COUNT   = 8'h04;
	localparam logic [7:0]  OFS_RELOAD  = 8'h08;
	localparam logic [7:0]  OFS_STATUS  = 8'h0c;
	localparam logic [7:0]  OFS_MASK    = 8'h10;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_W       = 8;
	localparam int          STAT_RELOAD  = 0;
	localparam logic [7:0]  RST_CTRL     = 8'h00;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [15:0] RST_RELOAD   = 16'h0000;
	localparam logic [15:0] RESTART_CNT  = 16'h0001;
	localparam logic [15:0] CNT_MAX      = 16'hffff;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBET_ONESHOT,
		SBET_COUNTER,
		SBET_CMP_COUNTER,
		SBET_RSVD
	} sbet_mode_t;

	// bit 7 out_en, 6:4 prescale exponent, 3 polarity, 2:1 mode, 0 enable
	typedef struct packed {
		logic       out_en;
		logic [2:0] prescale;
		logic       output_polarity_select;
		sbet_mode_t mode;
		logic       en;
	} sbet_ctrl_t;

endpackage

// [core/sbet_timer.sv]
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Function
// - count is a 16-bit up-counter advancing once per count event
// - reload 0001h with prescale 1 gives the shortest timeout
// - reload 0000h with prescale 128 gives the longest, full-range timeout
// - count at ffffh wraps to 0000h and keeps counting
// - one-shot: system clock counts to reload, interrupts, restarts 0001h, disables
// - counter mode: polarity picks counted pin edge and initial output level
// - counter mode: written start count only for first pass, then 0001h
// - counter mode: with prescale 1, edges seen equal present count minus start count
// - comparator mode: counts comparator edges chosen by polarity bit
// - comparator mode bypasses the prescaler
// - comparator mode reload: interrupt, restart 0001h, continue, invert output
module sbet_timer
	import sbet_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              timer_in,
	input  wire logic              cmp_out,
	output logic                   timer_out,
	output logic                   timer_out_oe,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sbet_ctrl_t  ctrl_ff;
	sbet_ctrl_t  nxt_ctrl;
	logic [15:0] count_ff;
	logic [15:0] nxt_count;
	logic [15:0] reload_ff;
	logic [6:0]  presc_ff;
	logic [6:0]  nxt_presc;
	logic        tin_ff;
	logic        cmp_ff;
	logic        tout_ff;
	logic        nxt_tout;
	logic        status_ff;
	logic        nxt_status;
	logic        mask_ff;
	logic [31:0] prdata_ff;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire         acc      = psel & penable;
	wire         wr       = acc & pwrite;
	wire         sel_ctrl = paddr == ADDR_W'(OFS_CTRL);
	wire         sel_cnt  = paddr == ADDR_W'(OFS_COUNT);
	wire         sel_rld  = paddr == ADDR_W'(OFS_RELOAD);
	wire         sel_stat = paddr == ADDR_W'(OFS_STATUS);
	wire         sel_mask = paddr == ADDR_W'(OFS_MASK);
	wire         mapped   = sel_ctrl | sel_cnt | sel_rld | sel_stat | sel_mask;
	wire         wr_ctrl  = wr & sel_ctrl;
	wire         wr_cnt   = wr & sel_cnt;
	wire         wr_rld   = wr & sel_rld;
	wire         wr_stat  = wr & sel_stat;
	wire         wr_mask  = wr & sel_mask;
	wire [31:0]  rdata    = sel_ctrl ? {24'h000000, ctrl_ff} :
	                        sel_cnt  ? {16'h0000, count_ff} :
	                        sel_rld  ? {16'h0000, reload_ff} :
	                        sel_stat ? {31'h00000000, status_ff} :
	                        sel_mask ? {31'h00000000, mask_ff} : 32'h00000000;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	assign prdata  = prdata_ff;

	// ----------------------------------------------------------------
	// count event selection
	// ----------------------------------------------------------------
	// polarity 0 counts rising edges, 1 counts falling edges
	wire         pol      = ctrl_ff.output_polarity_select;
	wire         tin_edge = pol ? (tin_ff & ~timer_in) : (~tin_ff & timer_in);
	wire         cmp_edge = pol ? (cmp_ff & ~cmp_out) : (~cmp_ff & cmp_out);
	wire         is_cmp   = ctrl_ff.mode == SBET_CMP_COUNTER;
	wire         is_cnt   = ctrl_ff.mode == SBET_COUNTER;
	wire         is_one   = ctrl_ff.mode == SBET_ONESHOT;
	wire [6:0]   plim     = 7'((8'h01 << ctrl_ff.prescale) - 8'h01);
	// the prescaler divides system clocks in one-shot and pin edges in counter mode
	wire         pre_evt  = ctrl_ff.en & ((is_one) | (is_cnt & tin_edge));
	wire         pre_tick = pre_evt & (presc_ff == plim);
	wire         adv_raw  = is_cmp ? (ctrl_ff.en & cmp_edge) : pre_tick;
	// a software write to the count in the same cycle wins over the advance
	wire         adv      = adv_raw & ~wr_cnt;
	wire         match    = count_ff == reload_ff;
	wire         reload   = adv & match;

	always_comb begin
		nxt_presc = presc_ff;
		if (!ctrl_ff.en || is_cmp) begin
			nxt_presc = 7'h00;
		end else if (pre_evt) begin
			nxt_presc = pre_tick ? 7'h00 : presc_ff + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// counter, control and output
	// ----------------------------------------------------------------
	always_comb begin
		nxt_count = count_ff;
		if (wr_cnt) begin
			nxt_count = pwdata[15:0];
		end else if (reload) begin
			nxt_count = RESTART_CNT;
		end else if (adv) begin
			nxt_count = count_ff + 16'h0001;
		end
	end

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = sbet_ctrl_t'(pwdata[CTRL_W-1:0]);
		end else if (reload && is_one) begin
			nxt_ctrl.en = 1'b0;
		end
	end

	always_comb begin
		nxt_tout = tout_ff;
		if (!ctrl_ff.en) begin
			nxt_tout = pol;
		end else if (reload && !is_one) begin
			nxt_tout = ~tout_ff;
		end
	end

	// hardware set wins over a write-one clear in the same cycle
	assign nxt_status = reload | (status_ff & ~(wr_stat & pwdata[STAT_RELOAD]));

	assign timer_out    = tout_ff;
	assign timer_out_oe = ctrl_ff.out_en;
	assign irq          = status_ff & mask_ff;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff   <= sbet_ctrl_t'(RST_CTRL);
			count_ff  <= RST_COUNT;
			reload_ff <= RST_RELOAD;
			presc_ff  <= 7'h00;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			count_ff  <= nxt_count;
			reload_ff <= wr_rld ? pwdata[15:0] : reload_ff;
			presc_ff  <= nxt_presc;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tin_ff    <= 1'b0;
			cmp_ff    <= 1'b0;
			tout_ff   <= 1'b0;
			status_ff <= 1'b0;
			mask_ff   <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			tin_ff    <= timer_in;
			cmp_ff    <= cmp_out;
			tout_ff   <= nxt_tout;
			status_ff <= nxt_status;
			mask_ff   <= wr_mask ? pwdata[0] : mask_ff;
			prdata_ff <= (psel && !penable) ? rdata : prdata_ff;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_count_inc: assert property (adv && !match |=> count_ff == $past(count_ff) + 16'h0001)
		else $error("count did not increment");
	a_count_wrap: assert property (adv && !match && count_ff == CNT_MAX |=>
		count_ff == 16'h0000)
		else $error("count did not wrap to zero");
	a_reload_one: assert property (reload |=> count_ff == RESTART_CNT && status_ff)
		else $error("reload did not restart at one");
	// a control write in the cycle after the stop may legally re-enable the timer
	a_oneshot_stop: assert property (reload && is_one && !wr_ctrl |=>
		!ctrl_ff.en ##1 (!ctrl_ff.en || $past(wr_ctrl)))
		else $error("one-shot did not disable");
	a_presc_gate: assert property (adv && !is_cmp |-> presc_ff == plim)
		else $error("advance without full prescale period");
	a_presc_min: assert property (ctrl_ff.en && is_one && ctrl_ff.prescale == 3'h0 &&
		!wr_cnt |-> adv)
		else $error("prescale one did not advance every clock");
	a_cmp_direct: assert property (ctrl_ff.en && is_cmp && cmp_edge && !wr_cnt |-> adv)
		else $error("comparator edge not counted directly");
	a_cmp_polarity: assert property (is_cmp && adv |->
		(pol ? $fell(cmp_out) : $rose(cmp_out)))
		else $error("comparator counted the wrong edge");
	a_tout_toggle: assert property (reload && !is_one |=> tout_ff != $past(tout_ff))
		else $error("output did not invert at reload");
	a_tout_idle: assert property (!ctrl_ff.en |=> tout_ff == $past(pol))
		else $error("idle output level differs from polarity");
	a_cnt_edge: assert property (is_cnt && adv |-> $past(timer_in) != timer_in)
		else $error("counter mode advanced without a pin edge");

	// ----------------------------------------------------------------
	// assertions: holding and edge qualification
	// ----------------------------------------------------------------
	// a count write beats the advance, so every hold check leaves it out
	a_count_hold: assert property (ctrl_ff.en && !adv && !wr_cnt |=>
		count_ff == $past(count_ff))
		else $error("count moved without a count event");
	a_halt_hold: assert property (!ctrl_ff.en && !wr_cnt |=> count_ff == $past(count_ff))
		else $error("disabled timer changed its count");
	a_write_wins: assert property (adv_raw && wr_cnt |=>
		count_ff == $past(pwdata[15:0]))
		else $error("count write lost against an advance");
	a_rsvd_idle: assert property (ctrl_ff.mode == SBET_RSVD |-> !adv)
		else $error("reserved mode advanced the count");
	a_cnt_hold: assert property (is_cnt && !tin_edge && !wr_cnt |=>
		count_ff == $past(count_ff))
		else $error("counter mode count moved between edges");
	a_cmp_hold: assert property (is_cmp && !cmp_edge && !wr_cnt |=>
		count_ff == $past(count_ff))
		else $error("comparator mode count moved between edges");
	a_cnt_polarity: assert property (is_cnt && adv |->
		(pol ? $fell(timer_in) : $rose(timer_in)))
		else $error("counter mode counted the wrong pin edge");

	// ----------------------------------------------------------------
	// assertions: prescaler
	// ----------------------------------------------------------------
	// the prescaler restarts whenever the timer is off, so every pass starts aligned
	a_presc_step: assert property (pre_evt && !pre_tick |=>
		presc_ff == $past(presc_ff) + 7'h01)
		else $error("prescaler did not step on a count event");
	a_presc_idle: assert property (!ctrl_ff.en |=> presc_ff == 7'h00)
		else $error("prescaler not cleared while disabled");
	a_cmp_nopresc: assert property (is_cmp |=> presc_ff == 7'h00)
		else $error("prescaler ran in comparator mode");
	// changing the prescale while running can misalign one pass; software disables first
	a_min_timeout: assert property (ctrl_ff.en && is_one && ctrl_ff.prescale == 3'h0 &&
		presc_ff == 7'h00 && count_ff == reload_ff && !wr_cnt && !wr_ctrl |=>
		!ctrl_ff.en && count_ff == RESTART_CNT)
		else $error("shortest one-shot did not end in one clock");

	// ----------------------------------------------------------------
	// assertions: reload and output
	// ----------------------------------------------------------------
	a_cnt_restart: assert property (reload && is_cnt && !wr_ctrl |=>
		count_ff == RESTART_CNT && ctrl_ff.en)
		else $error("counter mode did not restart and continue");
	a_cmp_restart: assert property (reload && is_cmp && !wr_ctrl |=>
		count_ff == RESTART_CNT && ctrl_ff.en)
		else $error("comparator mode did not restart and continue");
	a_reload_keep: assert property (!wr_rld |=> reload_ff == $past(reload_ff))
		else $error("reload value changed without a write");
	// while enabled, the output flips only at a reload in counter or comparator mode
	a_tout_hold: assert property (ctrl_ff.en && !reload |=> tout_ff == $past(tout_ff))
		else $error("output changed away from a reload");
	a_oneshot_tout: assert property (reload && is_one |=> tout_ff == $past(tout_ff))
		else $error("one-shot reload changed the output");

	// ----------------------------------------------------------------
	// assertions: status and interrupt
	// ----------------------------------------------------------------
	// the write-one clear loses to a reload in the same cycle
	a_status_hold: assert property (status_ff && !(wr_stat && pwdata[STAT_RELOAD]) |=>
		status_ff)
		else $error("status bit dropped without a clear");
	a_status_clear: assert property (wr_stat && pwdata[STAT_RELOAD] && !reload |=>
		!status_ff)
		else $error("status bit not cleared by a one");
	a_status_set: assert property (reload && wr_stat && pwdata[STAT_RELOAD] |=> status_ff)
		else $error("clear won over a reload event");
	a_mask_hold: assert property (!wr_mask |=> mask_ff == $past(mask_ff))
		else $error("mask changed without a write");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	// each mode's reload, the wrap and a falling-edge count
	c_oneshot_done: cover property (reload && is_one);
	c_cmp_reload: cover property (reload && is_cmp);
	c_cnt_reload: cover property (reload && is_cnt);
	c_wrap: cover property (adv && count_ff == CNT_MAX && !match);
	c_cnt_falling: cover property (is_cnt && adv && pol);

endmodule

// [testbench/sbet_src_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// pin and comparator source, one full pulse per request
// ----------------------------------------------------------------
module sbet_src_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic req,
	input  wire logic which,
	output logic      busy,
	output logic      timer_in,
	output logic      cmp_out
);
	logic [2:0] cnt_ff;
	logic       sel_ff;
	wire        hi = cnt_ff > 3'h2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
			sel_ff <= 1'b0;
		end else if (cnt_ff != 3'h0) begin
			cnt_ff <= cnt_ff - 3'h1;
		end else if (req) begin
			cnt_ff <= 3'h4;
			sel_ff <= which;
		end
	end
	// each phase stands two clocks, so the timer cannot miss an edge
	assign timer_in = !sel_ff && hi;
	assign cmp_out  = sel_ff && hi;
	assign busy     = cnt_ff != 3'h0;
endmodule

// [testbench/sbet_timer_tb.sv]
`timescale 1ns/10ps
module sbet_timer_tb;
	import sbet_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, timer_in, cmp_out, timer_out, timer_out_oe, irq;
	logic        req = 1'b0, which = 1'b0, busy;
	int          fails = 0, compares = 0;
	always #2 clk = ~clk;
	sbet_timer dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .timer_in(timer_in), .cmp_out(cmp_out),
		.timer_out(timer_out), .timer_out_oe(timer_out_oe), .irq(irq));
	sbet_src_model src (.clk(clk), .rst_n(rst_n), .req(req), .which(which),
		.busy(busy), .timer_in(timer_in), .cmp_out(cmp_out));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge clk);
		end
		if (pready !== 1'b1) begin
			fails++;
			$display("MISMATCH t=%0t bus answer never came", $time);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic w);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		which <= w;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1 && n < 16) begin
			n++;
			@(posedge clk);
		end
		if (busy === 1'b1) begin
			fails++;
			$display("MISMATCH t=%0t source pulse never ended", $time);
			test_done();
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rdchk(OFS_CTRL, 32'h0);
		rdchk(OFS_COUNT, 32'h0);
		rdchk(OFS_RELOAD, 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		rdchk(OFS_MASK, 32'h0);
		chk({29'h0, timer_out, timer_out_oe, irq}, 32'h0);
		bus(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("reset test done");
	endtask
	task automatic t_oneshot(input logic [15:0] c, input logic [15:0] r, input logic [2:0] p);
		int n;
		n = 0;
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_COUNT, {16'h0, c});
		bus(1'b1, OFS_RELOAD, {16'h0, r});
		bus(1'b1, OFS_MASK, 32'h1);
		bus(1'b1, OFS_CTRL, {25'h0, p, 4'h1});
		while (irq !== 1'b1 && n < 2000) begin
			n++;
			@(posedge clk);
		end
		if (irq !== 1'b1) begin
			fails++;
			$display("MISMATCH t=%0t one-shot never interrupted", $time);
			test_done();
		end
		rdchk(OFS_COUNT, 32'h1);
		rdchk(OFS_CTRL, {25'h0, p, 4'h0});
		bus(1'b1, OFS_STATUS, 32'h1);
		rdchk(OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("one-shot test done");
	endtask
	task automatic t_count(input logic pol);
		bus(1'b1, OFS_CTRL, {24'h0, 4'h8, pol, 3'h2});
		bus(1'b1, OFS_COUNT, 32'h1);
		bus(1'b1, OFS_RELOAD, 32'h3);
		bus(1'b1, OFS_MASK, 32'h1);
		chk({31'h0, timer_out}, {31'h0, pol});
		bus(1'b1, OFS_CTRL, {24'h0, 4'h8, pol, 3'h3});
		repeat (2) pulse(1'b0);
		rdchk(OFS_COUNT, 32'h3);
		pulse(1'b0);
		rdchk(OFS_COUNT, 32'h1);
		chk({30'h0, timer_out, irq}, {30'h0, ~pol, 1'b1});
		pulse(1'b0);
		rdchk(OFS_COUNT, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_STATUS, 32'h1);
		$display("counter test done");
	endtask
	task automatic t_cmp;
		bus(1'b1, OFS_CTRL, 32'hf4);
		bus(1'b1, OFS_COUNT, 32'h1);
		bus(1'b1, OFS_RELOAD, 32'h2);
		bus(1'b1, OFS_MASK, 32'h0);
		bus(1'b1, OFS_CTRL, 32'hf5);
		chk({31'h0, timer_out_oe}, 32'h1);
		pulse(1'b0);
		pulse(1'b1);
		rdchk(OFS_COUNT, 32'h2);
		pulse(1'b1);
		rdchk(OFS_COUNT, 32'h1);
		chk({30'h0, timer_out, irq}, 32'h2);
		bus(1'b1, OFS_MASK, 32'h1);
		rdchk(OFS_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h1);
		rdchk(OFS_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("comparator test done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_oneshot(16'h0001, 16'h0003, 3'h0);
		t_oneshot(16'h0001, 16'h0001, 3'h0);
		t_oneshot(16'hfffe, 16'h0002, 3'h7);
		t_count(1'b0);
		t_count(1'b1);
		t_cmp();
		test_done();
	end
endmodule
